// >>> hdl/a3wc_pkg.sv
package a3wc_pkg;
  // Register map and field layout of the area wait register.
  localparam logic [3:0] ADDR_WAIT_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int BYTE_ACCESS_SELECT_BIT = 20;
  localparam int EXT_WAIT_MASK_BIT = 6;
  localparam int READ_WAIT_LSB = 7;
  localparam logic [31:0] WRITE_MASK = 32'h0010_07C0;
  localparam logic [31:0] WAIT_CTRL_RESET = 32'h0000_0500;
  localparam logic [3:0] READ_WAIT_RESET = 4'hA;
  // One-hot state codes of the access sequencer.
  localparam logic [4:0] ST_IDLE = 5'h01;
  localparam logic [4:0] ST_SETUP = 5'h02;
  localparam logic [4:0] ST_WAIT = 5'h04;
  localparam logic [4:0] ST_EXT = 5'h08;
  localparam logic [4:0] ST_DONE = 5'h10;
  localparam logic [4:0] CNT_ZERO = 5'h00;
endpackage

// >>> hdl/a3wc_ctrl.sv
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Unused register bits always read zero.
// RULE2: Software writes zero to unused bits.
// RULE3: Byte-access bit shapes strobes for byte SRAM.
// RULE4: Clear: lane strobe pulses, direction is level.
// RULE5: Set: lane is level, direction pulses.
// RULE6: Read wait code maps to cycle count.
// RULE7: Software never writes codes 1101 to 1111.
// RULE8: Read wait field resets to 1010.
// RULE9: Mask bit clear honours external wait.
// RULE10: Mask applies even with zero wait count.
// RULE11: Honoured wait stretches access cycle by cycle.
module a3wc_ctrl (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Memory access request from the bus controller core.
  input wire logic mem_req_i,
  input wire logic mem_write_i,
  input wire logic byte_sram_i,
  output logic mem_done_o,
  // External memory pins, active low.
  input wire logic ext_wait_n_i,
  output logic area_select_n_o,
  output logic lane_select_strobe_n_o,
  output logic rd_wr_n_o,
  output logic rd_n_o
);

  typedef struct packed {
    logic byte_access_select;
    logic [3:0] read_wait_code;
    logic ext_wait_mask;
    logic [4:0] state;
    logic [4:0] cnt;
    logic is_write;
    logic byte_mode;
    logic [31:0] rdata;
    logic ack;
    logic done;
    logic cs_n;
    logic lane_n;
    logic rdwr_n;
    logic rd_n;
    logic wait_s1;
    logic wait_s2;
  } a3wc_state_t;

  a3wc_state_t s_q;
  a3wc_state_t s_d;

  // Wait code to cycle count translation.
  // Codes above six no longer count linearly, so a table is used.
  // Reserved codes fall back to the longest legal wait, the safe side for slow memory.
  function automatic logic [4:0] a3wc_wait_cycles(input logic [3:0] code);
    case (code)
      4'h7: a3wc_wait_cycles = 5'd8;
      4'h8: a3wc_wait_cycles = 5'd10;
      4'h9: a3wc_wait_cycles = 5'd12;
      4'hA: a3wc_wait_cycles = 5'd14;
      4'hB: a3wc_wait_cycles = 5'd18;
      4'hC: a3wc_wait_cycles = 5'd24;
      default: a3wc_wait_cycles = (code > 4'h6) ? 5'd24 : {1'b0, code};
    endcase
  endfunction

  // Next-state logic for register file and access sequencer.
  always_comb
  begin
    logic ext_hold;
    logic strobe_on;
    s_d = s_q;
    ext_hold = 1'b0;
    strobe_on = 1'b0;
    s_d.ack = 1'b0;
    s_d.done = 1'b0;
    // Pin input passes two flip-flops before use.
    // Only the second flip-flop is read, so a metastable first stage never reaches logic.
    s_d.wait_s1 = ~ext_wait_n_i;
    s_d.wait_s2 = s_q.wait_s1;
    // RULE9: mask gates wait.
    ext_hold = s_q.wait_s2 & ~s_q.ext_wait_mask;
    // A write lands at the edge where the master sees waitrequest low.
    // Landing it earlier would change the register before the transfer ends.
    if (avs_write_i && s_q.ack && avs_address_i == a3wc_pkg::ADDR_WAIT_CTRL)
    begin
      s_d.byte_access_select = avs_writedata_i[a3wc_pkg::BYTE_ACCESS_SELECT_BIT];
      s_d.read_wait_code = avs_writedata_i[a3wc_pkg::READ_WAIT_LSB +: 4];
      s_d.ext_wait_mask = avs_writedata_i[a3wc_pkg::EXT_WAIT_MASK_BIT];
    end
    // Bus slave answers one cycle after the request is seen.
    if ((avs_read_i | avs_write_i) & ~s_q.ack)
    begin
      s_d.ack = 1'b1;
      s_d.rdata = 32'h0000_0000;
      // RULE1: reserved reads zero.
      if (avs_address_i == a3wc_pkg::ADDR_WAIT_CTRL)
      begin
        s_d.rdata[a3wc_pkg::BYTE_ACCESS_SELECT_BIT] = s_q.byte_access_select;
        s_d.rdata[a3wc_pkg::READ_WAIT_LSB +: 4] = s_q.read_wait_code;
        s_d.rdata[a3wc_pkg::EXT_WAIT_MASK_BIT] = s_q.ext_wait_mask;
      end
      else if (avs_address_i == a3wc_pkg::ADDR_STATUS)
      begin
        s_d.rdata[4:0] = s_q.state;
        s_d.rdata[12:8] = s_q.cnt;
      end
    end
    // Access sequencer.
    case (s_q.state)
      a3wc_pkg::ST_IDLE:
      begin
        if (mem_req_i)
        begin
          s_d.is_write = mem_write_i;
          // RULE3: byte mode gate.
          s_d.byte_mode = byte_sram_i & s_q.byte_access_select;
          s_d.state = a3wc_pkg::ST_SETUP;
        end
      end
      a3wc_pkg::ST_SETUP:
      begin
        // RULE6: load wait count.
        s_d.cnt = a3wc_wait_cycles(s_q.read_wait_code);
        s_d.state = a3wc_pkg::ST_WAIT;
      end
      a3wc_pkg::ST_WAIT:
      begin
        if (s_q.cnt != a3wc_pkg::CNT_ZERO)
          s_d.cnt = s_q.cnt - 5'h01;
        // RULE10: wait checked at zero count.
        // An unmasked access always passes the wait state once, so that a wait
        // asserted at select time has crossed the synchroniser before the decision.
        else if (~s_q.ext_wait_mask)
          s_d.state = a3wc_pkg::ST_EXT;
        else
          s_d.state = a3wc_pkg::ST_DONE;
      end
      a3wc_pkg::ST_EXT:
      begin
        // RULE11: extend per cycle.
        // The access ends in the first cycle the synchronised wait is seen released.
        if (!ext_hold)
          s_d.state = a3wc_pkg::ST_DONE;
      end
      a3wc_pkg::ST_DONE:
      begin
        s_d.done = 1'b1;
        s_d.state = a3wc_pkg::ST_IDLE;
      end
      default: s_d.state = a3wc_pkg::ST_IDLE;
    endcase
    // Pin shaping for the next cycle.
    // Pins are worked out from the next state so they leave flip-flops aligned with it.
    s_d.cs_n = (s_d.state == a3wc_pkg::ST_IDLE);
    strobe_on = (s_d.state == a3wc_pkg::ST_WAIT) | (s_d.state == a3wc_pkg::ST_EXT);
    s_d.rd_n = ~(strobe_on & ~s_q.is_write & ~s_d.cs_n);
    if (s_d.cs_n)
    begin
      s_d.lane_n = 1'b1;
      s_d.rdwr_n = 1'b1;
    end
    else if (s_q.byte_mode)
    begin
      // RULE5: lane level, direction strobe.
      s_d.lane_n = 1'b0;
      s_d.rdwr_n = ~(strobe_on & s_q.is_write);
    end
    else
    begin
      // RULE4: lane strobe, direction level.
      s_d.lane_n = ~strobe_on;
      s_d.rdwr_n = ~s_q.is_write;
    end
  end

  // State register.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
      s_q.byte_access_select <= 1'b0;
      // RULE8: reset wait code.
      s_q.read_wait_code <= a3wc_pkg::READ_WAIT_RESET;
      s_q.ext_wait_mask <= 1'b0;
      s_q.state <= a3wc_pkg::ST_IDLE;
      s_q.cs_n <= 1'b1;
      s_q.lane_n <= 1'b1;
      s_q.rdwr_n <= 1'b1;
      s_q.rd_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from flip-flops.
  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = ~s_q.ack;
  assign mem_done_o = s_q.done;
  assign area_select_n_o = s_q.cs_n;
  assign lane_select_strobe_n_o = s_q.lane_n;
  assign rd_wr_n_o = s_q.rdwr_n;
  assign rd_n_o = s_q.rd_n;

endmodule // a3wc_ctrl

// >>> dv/a3wc_mem.sv
`timescale 1ns/1ps
module a3wc_mem (
  input wire logic clock_i,
  input wire logic area_select_n_i,
  input wire logic [7:0] hold_i,
  output logic ext_wait_n_o
);
  logic [7:0] c_q;
  // Counts the cycles since the area was selected.
  always_ff @(posedge clock_i)
    c_q <= area_select_n_i ? 8'h00 : c_q + 8'h01;
  assign ext_wait_n_o = area_select_n_i || c_q >= hold_i;
endmodule // a3wc_mem

// >>> dv/a3wc_asserts.sv
`timescale 1ns/1ps
module a3wc_chk (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic byte_sram_i,
  input wire logic mem_done_o,
  input wire logic ext_wait_n_i,
  input wire logic area_select_n_o,
  input wire logic lane_select_strobe_n_o,
  input wire logic rd_wr_n_o,
  input wire logic rd_n_o
);
  logic [31:0] r_q;
  logic [7:0] c_q;
  logic k, b, s, l;
  // Shorthands for a register read and the byte-access mode.
  assign k = avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h0;
  assign b = r_q[20] && byte_sram_i;
  assign s = area_select_n_o;
  assign l = lane_select_strobe_n_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Shadows the register and counts selected cycles.
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      r_q <= 32'h0000_0500;
      c_q <= 8'h00;
    end
    else
    begin
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0)
        r_q <= avs_writedata_i & 32'h0010_07C0;
      c_q <= s ? 8'h00 : c_q + 8'h01;
    end
  sequence s_wait;
    (!r_q[6] && !ext_wait_n_i && !s)[*4];
  endsequence
  a_resv_zero: assert property (k |-> !(avs_readdata_o & ~32'h0010_07C0)) else $error("resv");
  a_reg_value: assert property (k |-> avs_readdata_o == r_q) else $error("reg");
  a_lane_level: assert property (b && !l && !s |=> s || !l) else $error("lane");
  a_dir_level: assert property (!b && !rd_wr_n_o && !s |=> s || !rd_wr_n_o) else $error("dir");
  a_lane_inside: assert property ($fell(l) |-> !s) else $error("strobe");
  a_mask_bound: assert property (r_q[6] |-> c_q <= 8'd27) else $error("mask");
  a_wait_held: assert property (s_wait |=> !s) else $error("wait");
  a_done_end: assert property ($rose(s) |-> ##[0:1] mem_done_o) else $error("done");
  a_read_dir: assert property (!rd_n_o |-> !s && rd_wr_n_o) else $error("read");
endmodule // a3wc_chk
bind a3wc_ctrl a3wc_chk a3wc_chk_inst (.*);

// >>> dv/area3_wait_control_tb.sv
`timescale 1ns/1ps
module area3_wait_control_tb;
  logic clock_i = 0, rst_n_i = 0, rd = 0, wr = 0, rq = 0, mw = 0, bs = 0, wq, dn, wt, cs;
  logic [3:0] ad = 4'h0;
  logic [31:0] wd = 32'h0000_0000, q, v;
  logic [7:0] h = 8'h00;
  int n_mismatch = 0, compares = 0, n0, n, nr;
  int cy [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
  a3wc_ctrl a3wc_ctrl_inst (.clock_i, .rst_n_i, .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_readdata_o(q), .avs_waitrequest_o(wq), .mem_req_i(rq), .mem_write_i(mw),
    .byte_sram_i(bs), .mem_done_o(dn), .ext_wait_n_i(wt), .area_select_n_o(cs),
    .lane_select_strobe_n_o(), .rd_wr_n_o(), .rd_n_o());
  a3wc_mem a3wc_mem_inst (.clock_i, .area_select_n_i(cs), .hold_i(h), .ext_wait_n_o(wt));
  // Bus clock.
  initial forever #12.5 clock_i = ~clock_i;
  // Compares one value and counts it.
  task chk(input logic [31:0] g, e);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Prints the verdict and ends the run.
  task final_report;
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One bus transfer, held until waitrequest is seen low.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    do @(posedge clock_i); while (wq !== 1'b0);
    v = q;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clock_i);
  endtask
  // One memory access; n counts edges until done.
  task acc;
    rq <= 1'b1;
    @(posedge clock_i);
    rq <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (dn !== 1'b1);
    repeat (2) @(posedge clock_i);
  endtask
  // Every legal wait code, masked, against code zero.
  task t_wait;
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(v, 32'h0000_0500);
    acc;
    nr = n;
    for (int c = 0; c < 13; c++)
    begin
      bus(1'b1, 4'h0, 32'h0000_0040 | 32'(c << 7));
      acc;
      if (c == 0)
        n0 = n;
      chk(n - n0, cy[c]);
    end
    // Unmasked reset access: 14 waits plus one pass through the wait state.
    chk(nr - n0, 15);
  endtask
  // Reserved bits and an unmapped place read zero.
  task t_reg;
    bus(1'b1, 4'h0, 32'h0010_0640);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(v, 32'h0010_0640);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(v, 32'h0000_0000);
  endtask
  // Slow memory, masked and unmasked, in both strobe modes.
  task t_ext;
    h <= 8'd20;
    bs <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      mw <= m[0];
      bus(1'b1, 4'h0, {11'h000, m[1], 13'h0000, m[0], 6'h00});
      acc;
      chk(n > n0, !m[0]);
    end
  endtask
  // Reset, then the scenarios.
  initial
  begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_wait;
    t_reg;
    t_ext;
    final_report;
  end
  // Cuts a hang short.
  initial
  begin
    #200000;
    n_mismatch++;
    final_report;
  end
endmodule // area3_wait_control_tb
